/* inc/rail_supervisor_pkg.sv */
// Constants for the four-rail supervisor with watchdog.
// Assumes a single 25 MHz core clock; all pins arrive asynchronously.
package rail_supervisor_pkg;
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned NUM_CHANNELS = 4;
  // Fixed release delay, in microseconds
  localparam int unsigned FIXED_DELAY_US = 20_000;
  // Programmable delay base step per delay code unit, in microseconds
  localparam int unsigned PROG_STEP_US = 1_400;
  localparam int unsigned FIXED_DELAY_CYC =
    (FIXED_DELAY_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned PROG_STEP_CYC =
    (PROG_STEP_US * (CLK_FREQ_HZ / 1_000_000));
  // Watchdog timeout, in milliseconds
  localparam int unsigned WDOG_TIMEOUT_MS = 610;
  localparam longint unsigned WDOG_TIMEOUT_CYC =
    longint'(WDOG_TIMEOUT_MS) * longint'(CLK_FREQ_HZ / 1_000);
  localparam int unsigned DELAY_CODE_W = 4;
  localparam int unsigned CNT_W = 32;
  // Values after reset
  localparam logic FAULT_RESET_VAL = 1'b1;
  localparam logic WDOG_TIMEOUT_RESET_VAL = 1'b0;
endpackage

/* hw/release_delay_channel.sv */
// One supervisor channel: holds the fault asserted while the condition
// is present and releases it after the selected delay.
// Assumes fault_cond is already synchronised to core_clk.
`timescale 1ns/100ps
module release_delay_channel
  import rail_supervisor_pkg::*;
#(
  parameter int unsigned FIXED_CYC = FIXED_DELAY_CYC,
  parameter int unsigned STEP_CYC = PROG_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic fault_cond,
  input wire logic use_prog_delay,
  input wire logic [DELAY_CODE_W-1:0] delay_code,
  output logic fault_q
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;
  logic done;

  // Capacitor setting scales the delay; code zero still gives one step
  assign target = use_prog_delay ?
    CNT_W'(STEP_CYC) * CNT_W'({1'b0, delay_code} + 5'h01) :
    CNT_W'(FIXED_CYC);
  assign done = (cnt_q >= target - CNT_W'(1));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      fault_q <= FAULT_RESET_VAL;
    end else if (fault_cond) begin
      cnt_q <= '0;
      fault_q <= 1'b1;
    end else if (fault_q) begin
      if (done) begin
        fault_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end
endmodule // release_delay_channel

/* hw/quad_rail_supervisor_watchdog.sv */
// Four-channel rail supervisor with a watchdog on channel one's release.
// Assumes comparator results, delay straps and kick arrive as async pins.
`timescale 1ns/100ps
// Notes on behaviour
// - Low rail asserts that channel's fault
// - Upper window overvoltage asserts channel four fault
// - Manual input low asserts channel one fault
// - Fault output held low during fault
// - Release only after channel delay expires
// - Open-drain: pull low, float after delay
// - Open or resistor strap: fixed delay
// - Capacitor strap: programmable delay by value
// - Watchdog starts when channel one releases
// - Any kick edge restarts watchdog count
// - Timeout drives watchdog output low
// - No timeout keeps watchdog output inactive
module quad_rail_supervisor_watchdog
  import rail_supervisor_pkg::*;
#(
  parameter int unsigned FIXED_CYC = FIXED_DELAY_CYC,
  parameter int unsigned STEP_CYC = PROG_STEP_CYC,
  parameter longint unsigned WDOG_CYC = WDOG_TIMEOUT_CYC,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] rail_below_in,
  input wire logic window_lower_in,
  input wire logic window_upper_in,
  input wire logic manual_fault_in_n,
  input wire logic [3:0] delay_select_pin,
  input wire logic [4*DELAY_CODE_W-1:0] delay_code_in,
  input wire logic watchdog_kick_in,
  output logic [3:0] rail_fault_out,
  output logic [3:0] rail_fault_oe,
  output logic watchdog_timeout_out,
  output logic watchdog_timeout_oe
);
  // Raw pin bundle: rails 1..3, lower, upper, manual, kick, delay selects, delay codes
  localparam int unsigned NPIN = 11 + 4 * DELAY_CODE_W;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  assign pins = {delay_code_in, delay_select_pin, watchdog_kick_in,
                 manual_fault_in_n, window_upper_in, window_lower_in,
                 rail_below_in};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire [2:0] rail_low = sync2_q[2:0];
  wire lower_low = sync2_q[3];
  wire upper_high = sync2_q[4];
  wire manual_n = sync2_q[5];
  wire kick_s = sync2_q[6];
  wire [3:0] prog_sel = sync2_q[10:7];
  wire [4*DELAY_CODE_W-1:0] codes = sync2_q[NPIN-1:11];

  logic [3:0] cond;
  assign cond[0] = rail_low[0] | ~manual_n;
  assign cond[1] = rail_low[1];
  assign cond[2] = rail_low[2];
  assign cond[3] = lower_low | upper_high;

  logic [3:0] fault;
  for (genvar i = 0; i < 4; i++) begin : g_ch
    release_delay_channel #(
      .FIXED_CYC(FIXED_CYC),
      .STEP_CYC(STEP_CYC)
    ) u_ch (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .fault_cond(cond[i]),
      .use_prog_delay(prog_sel[i]),
      .delay_code(codes[i*DELAY_CODE_W +: DELAY_CODE_W]),
      .fault_q(fault[i])
    );
  end

  // Push-pull drives the level; open-drain only pulls low
  assign rail_fault_out = OPEN_DRAIN ? 4'h0 : ~fault;
  assign rail_fault_oe = OPEN_DRAIN ? fault : 4'hf;

  logic kick_prev_q;
  logic [63:0] watchdog_counter_q;
  logic wd_expired_q;
  wire kick_edge = kick_s ^ kick_prev_q;
  wire wd_run = ~fault[0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      kick_prev_q <= 1'b0;
      watchdog_counter_q <= '0;
      wd_expired_q <= WDOG_TIMEOUT_RESET_VAL;
    end else begin
      kick_prev_q <= kick_s;
      if (!wd_run || kick_edge) begin
        watchdog_counter_q <= '0;
        wd_expired_q <= 1'b0;
      end else if (watchdog_counter_q >= WDOG_CYC - 64'h1) begin
        wd_expired_q <= 1'b1;
      end else begin
        watchdog_counter_q <= watchdog_counter_q + 64'h1;
      end
    end
  end

  assign watchdog_timeout_out = OPEN_DRAIN ? 1'b0 : ~wd_expired_q;
  assign watchdog_timeout_oe = OPEN_DRAIN ? wd_expired_q : 1'b1;
endmodule // quad_rail_supervisor_watchdog

/* verification/rsw_asserts.sv */
// Port checker for the four-rail supervisor with watchdog.
// Assumes one clock domain; bound by the statement at the foot.
`timescale 1ns/100ps
module rsw_asserts #(
  parameter int unsigned FIXED_CYC = 10,
  parameter longint unsigned WDOG_CYC = 50,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic core_clk, sys_rst, window_lower_in, window_upper_in,
  input wire logic manual_fault_in_n, watchdog_kick_in, watchdog_timeout_out,
  input wire logic [2:0] rail_below_in,
  input wire logic [3:0] delay_select_pin, rail_fault_out, rail_fault_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] idle_q;
  logic kick_q;
  // Cycles since channel one released or the kick last moved
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_q <= '0;
      kick_q <= 1'b0;
    end else begin
      kick_q <= watchdog_kick_in;
      idle_q <= (!rail_fault_out[0] || kick_q != watchdog_kick_in) ? '0
        : idle_q + 32'h1;
    end
  end
  a_low_rail: assert property ($rose(rail_below_in[1]) |-> ##[1:4]
    !rail_fault_out[1]) else $error("rail two fault late");
  a_window_upper: assert property ($rose(window_upper_in) |-> ##[1:4]
    !rail_fault_out[3]) else $error("window fault late");
  a_manual_fault: assert property ($fell(manual_fault_in_n) |-> ##[1:4]
    !rail_fault_out[0]) else $error("manual fault late");
  a_fault_held: assert property (window_lower_in [*4] |->
    !rail_fault_out[3]) else $error("fault dropped early");
  a_release_delay: assert property ($rose(rail_fault_out[2]) &&
    !delay_select_pin[2] |-> !$past(rail_below_in[2], FIXED_CYC))
    else $error("release too soon");
  a_drive_enable: assert property (OPEN_DRAIN ?
    rail_fault_out == 4'h0 : rail_fault_oe == 4'hf)
    else $error("drive enable wrong");
  a_wdog_hold: assert property (!rail_fault_out[0] [*2] |->
    watchdog_timeout_out) else $error("watchdog ran during fault");
  a_kick_clears: assert property ($changed(watchdog_kick_in) |->
    ##[1:5] watchdog_timeout_out) else $error("kick ignored");
  a_timeout_low: assert property (idle_q == WDOG_CYC + 4 |->
    !watchdog_timeout_out) else $error("no timeout");
  a_no_early: assert property ($fell(watchdog_timeout_out) |->
    idle_q >= WDOG_CYC - 4) else $error("timeout too early");
  c_release: cover property ($rose(rail_fault_out[0]));
  c_timeout: cover property ($fell(watchdog_timeout_out));
  c_window: cover property ($rose(rail_fault_out[3]));
endmodule // rsw_asserts
bind quad_rail_supervisor_watchdog rsw_asserts #(.FIXED_CYC(FIXED_CYC),
  .WDOG_CYC(WDOG_CYC), .OPEN_DRAIN(OPEN_DRAIN)) u_chk (.*);

/* verification/rsw_host_model.sv */
// Processor model that toggles the watchdog kick on a set period.
// Assumes the supervisor's clock and reset.
`timescale 1ns/100ps
module rsw_host_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic kick_en,
  input wire logic [7:0] period,
  output logic kick_q
);
  logic [7:0] cnt_q;
  always_ff @(negedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      kick_q <= 1'b0;
    end else if (kick_en && cnt_q >= period) begin
      cnt_q <= 8'h00;
      kick_q <= ~kick_q;
    end else cnt_q <= cnt_q + 8'h01;
  end
endmodule // rsw_host_model

/* verification/quad_rail_supervisor_watchdog_bench.sv */
// Self-checking bench for the four-rail supervisor.
// Assumes shortened delays: fixed 10, step 5, watchdog 50 cycles.
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module quad_rail_supervisor_watchdog_bench;
  logic core_clk = 1'b0, sys_rst = 1'b1, kick_en = 1'b0;
  logic [2:0] rail_below_in = 3'h0;
  logic window_lower_in = 1'b0, window_upper_in = 1'b0;
  logic manual_fault_in_n = 1'b1, watchdog_kick_in;
  logic [3:0] delay_select_pin = 4'ha, rail_fault_out, rail_fault_oe;
  logic [15:0] delay_code_in = 16'h0030;
  logic watchdog_timeout_out, watchdog_timeout_oe;
  int errors = 0, n_compared = 0;
  always #20 core_clk = ~core_clk;
  quad_rail_supervisor_watchdog #(.FIXED_CYC(10), .STEP_CYC(5),
    .WDOG_CYC(50)) u_dut (.*);
  rsw_host_model u_host (.core_clk, .sys_rst, .kick_en, .period(8'h0a),
    .kick_q(watchdog_kick_in));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic set_c(input int ch, input logic v);
    if (ch == 0) manual_fault_in_n = ~v;
    else if (ch < 3) rail_below_in[ch] = v;
    else if (ch == 3) window_lower_in = v;
    else if (ch == 5) rail_below_in[0] = v;
    else window_upper_in = v;
  endtask
  // Assert, re-fault in mid-delay, then time the release
  task automatic t_chan(input int ch, input int tgt);
    int o, k;
    o = ch == 5 ? 0 : (ch > 3 ? 3 : ch);
    set_c(ch, 1'b1);
    cyc(4);
    `CHK(rail_fault_out[o], 1'b0)
    set_c(ch, 1'b0);
    cyc(tgt - 3);
    set_c(ch, 1'b1);
    cyc(2);
    set_c(ch, 1'b0);
    cyc(tgt);
    `CHK(rail_fault_out[o], 1'b0)
    for (k = 0; k < 8 && rail_fault_out[o] !== 1'b1; k++) cyc(1);
    `CHK(rail_fault_out[o], 1'b1)
    if (rail_fault_out[o] !== 1'b1) summarize();
  endtask
  task automatic t_wdog;
    kick_en = 1'b1;
    cyc(120);
    `CHK(watchdog_timeout_out, 1'b1)
    kick_en = 1'b0;
    cyc(60);
    `CHK(watchdog_timeout_out, 1'b0)
    set_c(0, 1'b1);
    cyc(80);
    `CHK(watchdog_timeout_out, 1'b1)
    set_c(0, 1'b0);
    cyc(45);
    `CHK(watchdog_timeout_out, 1'b1)
    cyc(30);
    `CHK(watchdog_timeout_out, 1'b0)
  endtask
  task automatic summarize;
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    `CHK(rail_fault_out, 4'h0)
    cyc(20);
    `CHK(rail_fault_out, 4'hf)
    `CHK(rail_fault_oe, 4'hf)
    `CHK(watchdog_timeout_oe, 1'b1)
    t_chan(0, 10);
    t_chan(1, 20);
    t_chan(2, 10);
    t_chan(3, 5);
    t_chan(4, 5);
    t_chan(5, 10);
    t_wdog();
    summarize();
  end
endmodule // quad_rail_supervisor_watchdog_bench
